//--- hw/adc_port_pkg.sv
package adc_port_pkg;

	// frame geometry
	localparam int ADDR_BITS = 4;
	localparam int CMD_BITS = 8;
	localparam int RESULT_BITS = 12;
	localparam int FRAME_FALLS = 12;
	localparam int SELECT_RISE = 4;
	localparam int SAMPLE_FALL = 4;
	localparam int CNT_W = 4;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CS_SETUP_NS = 1425;
	// least time, so round up
	localparam int CS_SETUP_CYCLES = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_W = 5;
	localparam int SAR_STEP_CYCLES = 8;
	localparam int STEP_W = 8;

	// buffering
	localparam int CMD_FIFO_DEPTH = 16;

	// reset values
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [3:0] CNT_ZERO = 4'h0;

	// one captured command word
	typedef struct packed {
		logic [ADDR_BITS-1:0] chan;
		logic [CMD_BITS-ADDR_BITS-1:0] extra;
	} cmd_t;

	typedef enum logic [1:0] {
		F_IDLE,
		F_SETUP,
		F_SHIFT,
		F_HOLD
	} frame_state_t;

	typedef enum logic [1:0] {
		C_IDLE,
		C_PUSH,
		C_CONV
	} conv_state_t;

endpackage : adc_port_pkg

//--- hw/cmd_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side, registered
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	// pointer wrap trick needs a power of two
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("cmd_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic empty;
	logic full;
	logic push;
	logic load;

	// extra pointer bit tells full from empty
	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready = !full;
	assign push = in_valid && in_ready;
	assign load = !empty && (!out_valid || out_ready);

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (load) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// output stage, so the drain side sees flops only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (load) begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr[AW-1:0]];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule : cmd_fifo

`default_nettype wire

//--- hw/adc_serial_port.sv
`timescale 1ns/100ps
`default_nettype none

module adc_serial_port
	import adc_port_pkg::*;
#(
	parameter int SETUP_CYCLES = adc_port_pkg::CS_SETUP_CYCLES,
	parameter int STEP_CYCLES = adc_port_pkg::SAR_STEP_CYCLES,
	parameter int FIFO_DEPTH = adc_port_pkg::CMD_FIFO_DEPTH
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// serial pins from the host
	input wire logic CS_N,
	input wire logic SHIFT_CLK,
	input wire logic CMD_IN,
	// three-state result pin and done flag
	output logic RESULT_OUT,
	output logic RESULT_OE,
	output logic CONV_DONE,
	// bit order, sampled at frame start
	input wire logic LSB_FIRST,
	// analog front end
	output logic [adc_port_pkg::ADDR_BITS-1:0] CHAN_SEL,
	output logic CHAN_VALID,
	output logic SAMPLE,
	output logic [adc_port_pkg::RESULT_BITS-1:0] DAC_CODE,
	input wire logic COMPARE_IN,
	// captured command words
	output logic CMD_VALID,
	output adc_port_pkg::cmd_t CMD_WORD,
	input wire logic CMD_READY
);
	import adc_port_pkg::*;

	generate
		if (SETUP_CYCLES < 1 || SETUP_CYCLES >= (1 << SETUP_W)) begin : g_bad_setup
			$error("SETUP_CYCLES out of range");
		end
		if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << STEP_W)) begin : g_bad_step
			$error("STEP_CYCLES out of range");
		end
	endgenerate

	localparam logic [SETUP_W-1:0] SETUP_LAST = SETUP_W'(SETUP_CYCLES - 1);
	localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
	localparam logic [CNT_W-1:0] RISE_SEL = CNT_W'(SELECT_RISE);
	localparam logic [CNT_W-1:0] RISE_CMD = CNT_W'(CMD_BITS);
	localparam logic [CNT_W-1:0] FALL_SAMPLE = CNT_W'(SAMPLE_FALL - 1);
	localparam logic [CNT_W-1:0] FALL_LAST = CNT_W'(FRAME_FALLS - 1);
	localparam logic [CNT_W-1:0] SAR_TOP = CNT_W'(RESULT_BITS - 1);

	// mirror a word for lsb-first shifting
	function automatic logic [RESULT_BITS-1:0] mirror(input logic [RESULT_BITS-1:0] w);
		logic [RESULT_BITS-1:0] r;
		r = '0;
		for (int i = 0; i < RESULT_BITS; i++) begin
			r[i] = w[RESULT_BITS-1-i];
		end
		return r;
	endfunction : mirror

	// pins come from the host's domain
	logic cs_meta, cs_s, cs_d;
	logic sclk_meta, sclk_s, sclk_d;
	logic din_meta, din_s;
	logic cs_fall, cs_rise, sclk_rise, sclk_fall;

	frame_state_t frame_state;
	logic [SETUP_W-1:0] setup_cnt;
	logic [CNT_W-1:0] rise_cnt;
	logic [CNT_W-1:0] fall_cnt;
	logic [CMD_BITS-1:0] cmd_shift;
	logic [RESULT_BITS-1:0] out_shift;
	logic last_fall;

	conv_state_t conv_state;
	logic [RESULT_BITS-1:0] result;
	logic [CNT_W-1:0] sar_bit;
	logic [STEP_W-1:0] step_cnt;
	cmd_t pending;
	logic push_valid;
	logic push_ready;

	// two flops before anything reads a pin
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cs_meta <= 1'b1;
			cs_s <= 1'b1;
			cs_d <= 1'b1;
			sclk_meta <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			din_meta <= 1'b0;
			din_s <= 1'b0;
		end else begin
			cs_meta <= CS_N;
			cs_s <= cs_meta;
			cs_d <= cs_s;
			sclk_meta <= SHIFT_CLK;
			sclk_s <= sclk_meta;
			sclk_d <= sclk_s;
			din_meta <= CMD_IN;
			din_s <= din_meta;
		end
	end

	assign cs_fall = cs_d && !cs_s;
	assign cs_rise = !cs_d && cs_s;
	assign sclk_rise = !sclk_d && sclk_s;
	assign sclk_fall = sclk_d && !sclk_s;
	assign last_fall = (frame_state == F_SHIFT) && sclk_fall && (fall_cnt == FALL_LAST);

	// frame sequencer
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			frame_state <= F_IDLE;
			setup_cnt <= '0;
		end else if (cs_rise) begin
			frame_state <= F_IDLE;
		end else begin
			unique case (frame_state)
				F_IDLE: begin
					if (cs_fall) begin
						frame_state <= F_SETUP;
						setup_cnt <= '0;
					end
				end
				F_SETUP: begin
					if (setup_cnt == SETUP_LAST) begin
						frame_state <= F_SHIFT;
					end else begin
						setup_cnt <= setup_cnt + 1'b1;
					end
				end
				F_SHIFT: begin
					if (last_fall) begin
						frame_state <= F_HOLD;
					end
				end
				F_HOLD: begin
					// extra clocks until the frame closes do nothing
					frame_state <= F_HOLD;
				end
			endcase
		end
	end

	// edge counters, only live while shifting
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rise_cnt <= CNT_ZERO;
			fall_cnt <= CNT_ZERO;
		end else if (cs_fall) begin
			rise_cnt <= CNT_ZERO;
			fall_cnt <= CNT_ZERO;
		end else if (frame_state == F_SHIFT) begin
			if (sclk_rise && rise_cnt != RISE_CMD) begin
				rise_cnt <= rise_cnt + 1'b1;
			end
			if (sclk_fall && !last_fall) begin
				fall_cnt <= fall_cnt + 1'b1;
			end
		end
	end

	// command capture
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cmd_shift <= '0;
		end else if (frame_state == F_SHIFT && sclk_rise && rise_cnt != RISE_CMD) begin
			cmd_shift <= {cmd_shift[CMD_BITS-2:0], din_s};
		end
	end

	// channel select, valid after the fourth rise
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CHAN_SEL <= '0;
			CHAN_VALID <= 1'b0;
		end else if (cs_fall) begin
			CHAN_VALID <= 1'b0;
		end else if (frame_state == F_SHIFT && sclk_rise && rise_cnt == RISE_SEL - 1'b1) begin
			CHAN_SEL <= {cmd_shift[ADDR_BITS-2:0], din_s};
			CHAN_VALID <= 1'b1;
		end
	end

	// sampling window on the capacitor array
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			SAMPLE <= 1'b0;
		end else if (cs_rise || last_fall || cs_fall) begin
			SAMPLE <= 1'b0;
		end else if (frame_state == F_SHIFT && sclk_fall && fall_cnt == FALL_SAMPLE) begin
			SAMPLE <= 1'b1;
		end
	end

	// result pin; the host samples on rises, so we only move on falls
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			out_shift <= '0;
			RESULT_OUT <= 1'b0;
			RESULT_OE <= 1'b0;
		end else if (cs_rise) begin
			RESULT_OE <= 1'b0;
		end else if (cs_fall) begin
			out_shift <= LSB_FIRST ? mirror(result) : result;
			RESULT_OUT <= LSB_FIRST ? result[0] : result[RESULT_BITS-1];
			RESULT_OE <= 1'b1;
		end else if (frame_state == F_SHIFT && sclk_fall && !last_fall) begin
			out_shift <= {out_shift[RESULT_BITS-2:0], 1'b0};
			RESULT_OUT <= out_shift[RESULT_BITS-2];
		end
	end

	// converter: waits for the command to be queued, then runs the sar
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			conv_state <= C_IDLE;
			CONV_DONE <= 1'b1;
			result <= RESULT_RESET;
			DAC_CODE <= '0;
			sar_bit <= CNT_ZERO;
			step_cnt <= '0;
			pending <= '0;
		end else begin
			unique case (conv_state)
				C_IDLE: begin
					if (last_fall) begin
						conv_state <= C_PUSH;
						CONV_DONE <= 1'b0;
						pending <= cmd_t'(cmd_shift);
					end
				end
				C_PUSH: begin
					// a full queue stalls the conversion start
					if (push_ready) begin
						conv_state <= C_CONV;
						sar_bit <= SAR_TOP;
						step_cnt <= '0;
						DAC_CODE <= {1'b1, {(RESULT_BITS-1){1'b0}}};
					end
				end
				C_CONV: begin
					if (step_cnt != STEP_LAST) begin
						step_cnt <= step_cnt + 1'b1;
					end else begin
						step_cnt <= '0;
						if (sar_bit == CNT_ZERO) begin
							result <= COMPARE_IN ? DAC_CODE : DAC_CODE & ~RESULT_BITS'(1);
							CONV_DONE <= 1'b1;
							conv_state <= C_IDLE;
						end else begin
							DAC_CODE[sar_bit] <= COMPARE_IN;
							DAC_CODE[sar_bit - 1'b1] <= 1'b1;
							sar_bit <= sar_bit - 1'b1;
						end
					end
				end
				default: begin
					conv_state <= C_IDLE;
				end
			endcase
		end
	end

	assign push_valid = (conv_state == C_PUSH);

	// queue of captured command words
	cmd_fifo #(
		.WIDTH($bits(cmd_t)),
		.DEPTH(FIFO_DEPTH)
	) u_cmd_fifo (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.in_valid(push_valid),
		.in_data(pending),
		.in_ready(push_ready),
		.out_valid(CMD_VALID),
		.out_data(CMD_WORD),
		.out_ready(CMD_READY)
	);

endmodule : adc_serial_port

`default_nettype wire

//--- bench/adc_port_chk.sv
`timescale 1ns/100ps
`default_nettype none

module adc_port_chk #(
	parameter int STEP_CYCLES = 8
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// link pins
	input wire logic CS_N,
	input wire logic SHIFT_CLK,
	input wire logic RESULT_OUT,
	input wire logic RESULT_OE,
	input wire logic CONV_DONE,
	// front end and buffer
	input wire logic [3:0] CHAN_SEL,
	input wire logic CHAN_VALID,
	input wire logic SAMPLE,
	input wire logic CMD_VALID
);
	// slack covers push and result store
	localparam int CONV_MAX = 12 * STEP_CYCLES + 20;
	logic [2:0] sc;
	logic fall;

	// own shift-clock synchroniser, same depth as the port's
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sc <= 3'h0;
		end else begin
			sc <= {sc[1:0], SHIFT_CLK};
		end
	end
	assign fall = sc[2] & ~sc[1];

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	// properties, one per behaviour
	property p_off; CS_N [*5] |-> !RESULT_OE; endproperty
	property p_on; (!CS_N) [*6] |-> RESULT_OE; endproperty
	property p_edge; $changed(RESULT_OUT) && RESULT_OE && $past(RESULT_OE)
		|-> $past(fall) || $past(fall, 2) || $past(fall, 3); endproperty
	property p_done_low; $fell(CONV_DONE) |-> $fell(SAMPLE); endproperty
	property p_conv; $fell(CONV_DONE) && !CMD_VALID |-> ##[1:CONV_MAX] CONV_DONE; endproperty
	property p_sel_hold; CHAN_VALID && $past(CHAN_VALID) |-> $stable(CHAN_SEL); endproperty
	property p_sample; $rose(SAMPLE) |-> CHAN_VALID && RESULT_OE; endproperty
	property p_clear; $rose(RESULT_OE) |-> ##[0:1] !CHAN_VALID; endproperty
	property p_quiet; CS_N [*5] |=> $stable(CHAN_SEL); endproperty

	a_off: assert property (p_off) else $error("result pin driven while deselected");
	a_on: assert property (p_on) else $error("result pin not driven in frame");
	a_edge: assert property (p_edge) else $error("result bit moved without a fall");
	a_done_low: assert property (p_done_low) else $error("done fell apart from window end");
	a_conv: assert property (p_conv) else $error("conversion did not finish");
	a_sel_hold: assert property (p_sel_hold) else $error("select moved while valid");
	a_sample: assert property (p_sample) else $error("sampling began too early");
	a_clear: assert property (p_clear) else $error("frame start kept old select");
	a_quiet: assert property (p_quiet) else $error("select moved outside a frame");

	// main scenarios reached
	c_conv: cover property ($fell(CONV_DONE));
	c_sel: cover property ($rose(CHAN_VALID));
	c_frame: cover property ($rose(RESULT_OE));
endmodule : adc_port_chk

bind adc_serial_port adc_port_chk #(.STEP_CYCLES(STEP_CYCLES)) u_adc_port_chk (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CS_N(CS_N), .SHIFT_CLK(SHIFT_CLK),
	.RESULT_OUT(RESULT_OUT), .RESULT_OE(RESULT_OE), .CONV_DONE(CONV_DONE),
	.CHAN_SEL(CHAN_SEL), .CHAN_VALID(CHAN_VALID), .SAMPLE(SAMPLE), .CMD_VALID(CMD_VALID)
);

`default_nettype wire

//--- bench/adc_host.sv
`timescale 1ns/100ps
`default_nettype none

module adc_host (
	// pins to the port
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	logic [11:0] rd;

	// idle: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end

	// one frame of n clocks; fewer than 12 aborts
	task automatic frame(input logic [7:0] cmd, input int n);
		cs_n = 1'b0;
		#1500;
		for (int i = 0; i < n; i++) begin
			// command msb first, result taken on rises
			din = cmd[7 - (i % 8)];
			#400 sclk = 1'b1;
			rd = {rd[10:0], dout};
			#400 sclk = 1'b0;
		end
		#400 cs_n = 1'b1;
		// released line must not look like held data
		din = ~din;
	endtask : frame

	// clocks while deselected; the port must ignore them
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			#400 sclk = 1'b1;
			#400 sclk = 1'b0;
		end
	endtask : idle_clocks
endmodule : adc_host

`default_nettype wire

//--- bench/serial_adc_control_port_bench.sv
`timescale 1ns/100ps
`default_nettype none

module serial_adc_control_port_bench;
	import adc_port_pkg::*;
	typedef struct packed {
		logic [7:0] cmd;
		logic [11:0] vin;
		logic lsb;
		logic [11:0] rd;
	} row_t;
	logic clk, rst_n, lsb, rdy, cs_n, sclk, din, rout, oe, done, chv, smp, cmpv, cvalid;
	logic [3:0] chan;
	logic [11:0] dac, vin;
	cmd_t cword;
	wire dout;
	int n_errors, num_checks, cyc;
	logic [7:0] q[$];
	// read value is the previous row's input, reversed when lsb first
	row_t rows[4] = '{'{8'hA5, 12'hFFF, 1'b0, 12'h000}, '{8'h3C, 12'h800, 1'b1, 12'hFFF},
		'{8'hD2, 12'h001, 1'b0, 12'h800}, '{8'h07, 12'h5A3, 1'b1, 12'h800}};

	// released pin floats; comparator follows the held input
	assign dout = oe ? rout : 1'bz;
	assign cmpv = (vin >= dac);

	adc_serial_port #(.SETUP_CYCLES(2), .STEP_CYCLES(1)) u_adc_serial_port (
		.CLK_SYS(clk), .RST_N(rst_n), .CS_N(cs_n), .SHIFT_CLK(sclk), .CMD_IN(din),
		.RESULT_OUT(rout), .RESULT_OE(oe), .CONV_DONE(done), .LSB_FIRST(lsb),
		.CHAN_SEL(chan), .CHAN_VALID(chv), .SAMPLE(smp), .DAC_CODE(dac), .COMPARE_IN(cmpv),
		.CMD_VALID(cvalid), .CMD_WORD(cword), .CMD_READY(rdy));
	adc_host u_adc_host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// bounded wait for the done flag
	task automatic wait_done;
		for (int i = 0; i < 300 && done !== 1'b1; i++) tick(1);
		check(12'(done), 12'h001);
	endtask : wait_done

	task automatic rst_chk;
		check(12'({oe, done, chv, cvalid, smp}), 12'h008);
	endtask : rst_chk

	task automatic results;
		$display("checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// hang guard, a run needs about 2700 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			n_errors++;
			results;
		end
	end

	initial begin
		rst_n = 1'b0;
		lsb = 1'b0;
		rdy = 1'b0;
		vin = 12'h000;
		tick(3);
		rst_chk;
		tick(2);
		rst_n = 1'b1;
		tick(1);
		foreach (rows[i]) begin
			lsb = rows[i].lsb;
			vin = rows[i].vin;
			u_adc_host.frame(rows[i].cmd, 12);
			q.push_back(rows[i].cmd);
			check(u_adc_host.rd, rows[i].rd);
			check(12'(chan), 12'(rows[i].cmd[7:4]));
			check(12'(chv), 12'h001);
			tick(2);
			check(12'(done), 12'h000);
			wait_done;
			$display("row %0d done", i);
		end
		// drain side stalls until the buffer refuses
		for (int i = 4; i < 18; i++) begin
			u_adc_host.frame(8'(i), 12);
			q.push_back(8'(i));
			if (i < 17) begin
				wait_done;
			end else begin
				tick(60);
				check(12'(done), 12'h000);
			end
		end
		$display("fill done");
		rdy = 1'b1;
		// a word standing now is taken at the next edge, ready held high
		for (int i = 0; i < 300 && q.size() > 0; i++) begin
			if (cvalid === 1'b1) check(12'(cword), 12'(q.pop_front()));
			tick(1);
		end
		check(12'(q.size()), 12'h000);
		tick(1);
		wait_done;
		$display("drain done");
		// frame cut short after six clocks
		u_adc_host.frame(8'h3C, 6);
		tick(30);
		check(12'(chan), 12'h003);
		check(12'({done, cvalid}), 12'h002);
		// clocks with the port deselected change nothing
		u_adc_host.idle_clocks(12);
		tick(4);
		check(12'({done, cvalid, oe, chv}), 12'h009);
		check(12'(chan), 12'h003);
		$display("abort done");
		// reset mid-run clears the stored result
		rst_n = 1'b0;
		tick(2);
		rst_chk;
		rst_n = 1'b1;
		tick(1);
		lsb = 1'b0;
		u_adc_host.frame(8'h11, 12);
		check(u_adc_host.rd, 12'h000);
		wait_done;
		$display("reset done");
		results;
	end
endmodule : serial_adc_control_port_bench

`default_nettype wire
